// >>> bench/serial_tx_model.sv
// Remote serial transmitter driving the receive line.
// Assumes the receiver takes one sample tick per clk.
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock.
  input wire logic clk,
  // Serial line, idle high.
  output logic line
);
  // ********************************************
  // Frame tasks
  // ********************************************
  // The line rests high between frames.
  initial line = 1'b1;
  // One bit time; a requested glitch flips the middle clock only.
  task automatic put(input logic lvl, input bit g);
    for (int i = 0; i < BIT_CLKS; i++) begin
      @(posedge clk);
      line <= (g && i == BIT_CLKS / 2) ? !lvl : lvl;
    end
  endtask : put
  // Start bit, data, then a single stop bit of the given level.
  task automatic send(input logic [8:0] w, input int n, input logic stp, input int gb);
    put(1'b0, 1'b0);
    for (int b = 0; b < n; b++) begin
      put(w[b], b == gb);
    end
    put(stp, 1'b0);
    @(posedge clk);
    line <= 1'b1;
  endtask : send
  // A break: low for many bit times, then high again.
  task automatic hold_low(input int bits);
    for (int b = 0; b < bits; b++) begin
      put(1'b0, 1'b0);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask : hold_low
  // A short low pulse, too short to pass the mid-bit start check.
  task automatic blip(input int clks);
    for (int i = 0; i < clks; i++) begin
      @(posedge clk);
      line <= 1'b0;
    end
    @(posedge clk);
    line <= 1'b1;
  endtask : blip
endmodule : serial_tx_model

// >>> bench/tb_uart_receiver_fifo.sv
// Self-checking bench for the UART receive channel.
// Assumes BAUD is set to 0, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module tb_uart_receiver_fifo;
  // ********************************************
  // Signals, clock and instances
  // ********************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line;
  logic rx_int_req;
  int err_count = 0;
  int checked = 0;
  // Free-running 25 MHz clock.
  always #20 clk = ~clk;
  uart_receiver_fifo #(.DEPTH(4)) u_uart_receiver_fifo (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_line_pin(line), .rx_int_req(rx_int_req));
  serial_tx_model #(.BIT_CLKS(16)) u_serial_tx_model (.clk(clk), .line(line));
  // ********************************************
  // Shared tasks
  // ********************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; only the watchdog ends a wait for pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask : rd
  // Status read, then data read: the only sequence that pops a word.
  task automatic pop(input logic [31:0] d, input logic [31:0] sx, input logic [31:0] sm);
    rd(uart_rx_pkg::OFS_STAT, sx, sm);
    rd(uart_rx_pkg::OFS_DATA, d);
  endtask : pop
  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(uart_rx_pkg::OFS_CTRL, {24'h0, uart_rx_pkg::CTRL_RST});
    rd(uart_rx_pkg::OFS_BAUD, {16'h0, uart_rx_pkg::BAUD_RST});
    rd(uart_rx_pkg::OFS_STAT, 32'h20);
    rd(uart_rx_pkg::OFS_CNT, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset
  // Five back-to-back frames into a four-word FIFO with trigger level four.
  task automatic t_fill;
    logic [7:0] v [5] = '{8'h5a, 8'h3c, 8'h81, 8'hf0, 8'h11};
    wr(uart_rx_pkg::OFS_BAUD, 32'h0);
    wr(uart_rx_pkg::OFS_CTRL, 32'he1);
    for (int i = 0; i < 5; i++) begin
      u_serial_tx_model.send({1'b0, v[i]}, 8, 1'b1, -1);
      repeat (4) @(posedge clk);
      chk({31'h0, rx_int_req}, {31'h0, i >= 3});
    end
    rd(uart_rx_pkg::OFS_CNT, 32'h4);
    rd(uart_rx_pkg::OFS_STAT, 32'h3, 32'h3);
    wr(uart_rx_pkg::OFS_CTRL, 32'hc1);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_int_req}, 32'h0);
    wr(uart_rx_pkg::OFS_CTRL, 32'he1);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_int_req}, 32'h1);
    rd(uart_rx_pkg::OFS_DATA, 32'h5a);
    rd(uart_rx_pkg::OFS_DATA, 32'h3c);
    rd(uart_rx_pkg::OFS_CNT, 32'h3);
    rd(uart_rx_pkg::OFS_STAT, 32'h0, 32'h2);
    rd(uart_rx_pkg::OFS_DATA, 32'h3c);
    pop(32'h81, 32'h1, 32'h1);
    pop(32'hf0, 32'h1, 32'h1);
    rd(uart_rx_pkg::OFS_STAT, 32'h0, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_int_req}, 32'h0);
  endtask : t_fill
  // Disabled receiver ignores the line; then a nine-bit word.
  task automatic t_nine;
    wr(uart_rx_pkg::OFS_CTRL, 32'h0);
    u_serial_tx_model.send(9'h0a5, 8, 1'b1, -1);
    rd(uart_rx_pkg::OFS_CNT, 32'h0);
    wr(uart_rx_pkg::OFS_CTRL, 32'h03);
    fork
      u_serial_tx_model.send(9'h1a5, 9, 1'b1, -1);
      begin
        repeat (60) @(posedge clk);
        rd(uart_rx_pkg::OFS_STAT, 32'h0, 32'h21);
      end
    join
    repeat (4) @(posedge clk);
    pop(32'ha5, 32'h61, 32'h7f);
  endtask : t_nine
  // Parity, framing, noise and break, each popped and cleared.
  task automatic t_errors;
    wr(uart_rx_pkg::OFS_CTRL, 32'h05);
    u_serial_tx_model.send(9'h001, 8, 1'b1, -1);
    pop(32'h01, 32'h10, 32'h10);
    wr(uart_rx_pkg::OFS_CTRL, 32'h0d);
    u_serial_tx_model.send(9'h001, 8, 1'b1, -1);
    pop(32'h01, 32'h0, 32'h10);
    wr(uart_rx_pkg::OFS_CTRL, 32'h01);
    u_serial_tx_model.send(9'h055, 8, 1'b0, -1);
    pop(32'h55, 32'h8, 32'h8);
    u_serial_tx_model.send(9'h033, 8, 1'b1, 2);
    pop(32'h33, 32'h5, 32'h5);
    rd(uart_rx_pkg::OFS_STAT, 32'h0, 32'h4);
    u_serial_tx_model.hold_low(20);
    repeat (40) @(posedge clk);
    rd(uart_rx_pkg::OFS_CNT, 32'h1);
    pop(32'h00, 32'h29, 32'h29);
    // A short low pulse must be rejected and leave the receiver idle.
    u_serial_tx_model.blip(4);
    repeat (40) @(posedge clk);
    rd(uart_rx_pkg::OFS_CNT, 32'h0);
    rd(uart_rx_pkg::OFS_STAT, 32'h20, 32'h20);
  endtask : t_errors
  // ********************************************
  // Sequence, watchdog and verdict
  // ********************************************
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Reset for 20 cycles, then the scenarios in order.
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_fill();
    t_nine();
    t_errors();
    tally_and_finish();
  end
  // The tests need under 6000 cycles; this limit leaves ample slack.
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_uart_receiver_fifo

// >>> bench/uart_receiver_fifo_checker.sv
// Port-level checker for the UART receive channel.
// Assumes it is bound to uart_receiver_fifo and sees only its ports.
`timescale 1ns/1ps
module uart_receiver_fifo_checker #(
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and interrupt.
  input wire logic serial_line_pin,
  input wire logic rx_int_req
);
  // ********************************************
  // Decodes and properties
  // ********************************************
  // Access phase, read access and a hit on the five mapped words.
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic mapped = paddr <= uart_rx_pkg::OFS_CNT && paddr[1:0] == 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_acc;
    pslverr |-> psel && penable;
  endproperty
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
  property p_err_unmap;
    acc && !mapped |-> pslverr && prdata == 32'h0;
  endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");
  property p_no_err;
    acc && mapped |-> !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("mapped access refused");
  property p_cnt;
    rd && paddr == uart_rx_pkg::OFS_CNT |-> prdata <= DEPTH;
  endproperty
  a_cnt: assert property (p_cnt) else $error("fill count above depth");
  property p_data;
    rd && paddr == uart_rx_pkg::OFS_DATA |-> prdata[31:8] == 24'h0;
  endproperty
  a_data: assert property (p_data) else $error("data port upper bits set");
  property p_stat;
    rd && paddr == uart_rx_pkg::OFS_STAT |-> prdata[31:7] == 25'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  property p_int_mask;
    acc && pwrite && paddr == uart_rx_pkg::OFS_CTRL && !pwdata[5] |-> ##2 !rx_int_req;
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("interrupt not masked");
  // The request only drops after a pop or a control write two edges back.
  property p_int_fall;
    $fell(rx_int_req) |-> $past(acc, 2);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt dropped without cause");
  c_full: cover property (rd && paddr == uart_rx_pkg::OFS_CNT && prdata == DEPTH);
  c_err: cover property (pslverr);
  c_int: cover property ($rose(rx_int_req));
endmodule : uart_receiver_fifo_checker

bind uart_receiver_fifo uart_receiver_fifo_checker #(.DEPTH(DEPTH)) u_chk (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_line_pin(serial_line_pin), .rx_int_req(rx_int_req));

// >>> hw/majority_vote.sv
// Three-sample majority voter with a disagreement (noise) indication.
// Assumes line is already synchronised to clk.
`timescale 1ns/1ps
module majority_vote (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Sample strobe and synchronised line level.
  input wire logic sample,
  input wire logic line,
  // Voted level and noise indication.
  output logic vote,
  output logic noisy
);

  logic [2:0] smp_q;

  // The three most recent samples; idle-high so a fresh frame votes high.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      smp_q <= 3'h7;
    end else if (sample) begin
      smp_q <= {smp_q[1:0], line};
    end
  end

  // Two of three wins; any disagreement marks noise.
  assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  assign noisy = ~((smp_q[0] == smp_q[1]) && (smp_q[1] == smp_q[2]));

endmodule : majority_vote

// >>> hw/uart_receiver_fifo.sv
// UART receive channel: oversampled bit recovery, word FIFO, status flags.
// Assumes an APB master on clk and a serial line asynchronous to clk.
`timescale 1ns/1ps
module uart_receiver_fifo #(
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line, receive direction only.
  input wire logic serial_line_pin,
  // Receive interrupt request.
  output logic rx_int_req
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // ************************************************************
  // Registers and state
  // ************************************************************
  uart_rx_pkg::ctrl_type ctrl_q;
  logic [15:0] baud_q;
  logic [15:0] bcnt_q;
  logic line_m_q;
  logic line_s_q;
  logic line_p_q;
  uart_rx_pkg::rx_state_type state_q;
  uart_rx_pkg::rx_state_type state_d;
  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic [3:0] bitn_q;
  logic [8:0] shift_q;
  logic nacc_q;
  logic idle_q;
  logic ovr_q;
  logic noise_q;
  logic fe_q;
  logic pe_q;
  logic armed_q;
  logic int_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  uart_rx_pkg::word_type mem [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_ctrl = paddr == uart_rx_pkg::OFS_CTRL;
  wire hit_baud = paddr == uart_rx_pkg::OFS_BAUD;
  wire hit_stat = paddr == uart_rx_pkg::OFS_STAT;
  wire hit_data = paddr == uart_rx_pkg::OFS_DATA;
  wire hit_cnt = paddr == uart_rx_pkg::OFS_CNT;
  wire mapped = hit_ctrl | hit_baud | hit_stat | hit_data | hit_cnt;
  wire stat_rd = rd & hit_stat;
  wire data_rd = rd & hit_data;
  // A data read only completes the clear sequence after a status read.
  wire seq_clr = data_rd & armed_q;

  // ************************************************************
  // Baud tick and line synchroniser
  // ************************************************************
  // One tick per sixteenth of a bit; divide clk by baud_q + 1.
  // A count left above a smaller new divisor ends at once instead of wrapping.
  wire tick = bcnt_q >= baud_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bcnt_q <= 16'h0000;
    end else begin
      bcnt_q <= tick ? 16'h0000 : bcnt_q + 16'h0001;
    end
  end

  // Two flip-flops before any logic; a third keeps the previous level.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_m_q <= 1'b1;
      line_s_q <= 1'b1;
      line_p_q <= 1'b1;
    end else begin
      line_m_q <= serial_line_pin;
      line_s_q <= line_m_q;
      line_p_q <= line_s_q;
    end
  end

  // ************************************************************
  // Bit recovery
  // ************************************************************
  wire fall = line_p_q & ~line_s_q;
  wire samp = tick && phase_q >= uart_rx_pkg::PH_S0 && phase_q <= uart_rx_pkg::PH_S2;
  wire dec = tick && phase_q == uart_rx_pkg::PH_DEC;
  wire vote;
  wire noisy;

  // Three samples in the middle of each bit decide its level.
  majority_vote u_vote (
    .clk(clk),
    .rstn(rstn),
    .sample(samp),
    .line(line_s_q),
    .vote(vote),
    .noisy(noisy)
  );

  wire nine = ctrl_q.word_len_nine_sel;
  wire last_bit = bitn_q == (nine ? uart_rx_pkg::BITS_9 : uart_rx_pkg::BITS_8);
  wire start_det = state_q == uart_rx_pkg::RX_IDLE && ctrl_q.rx_enable_bit && fall;
  // Only one stop bit is looked at, whatever the sender uses.
  wire word_done = state_q == uart_rx_pkg::RX_STOP && dec;
  // An 8-bit word sits in the upper bits after eight right shifts.
  wire [8:0] word = nine ? shift_q : {1'b0, shift_q[8:1]};
  wire par_x = ^word;
  wire par_chk = ctrl_q.parity_enable_bit && !ctrl_q.parity_type_sel[1];
  wire par_bad = par_chk && (par_x != (ctrl_q.parity_type_sel == uart_rx_pkg::PAR_ODD));

  // Next state of the frame sequencer.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uart_rx_pkg::RX_IDLE: begin
        if (start_det) begin
          state_d = uart_rx_pkg::RX_START;
        end
      end
      uart_rx_pkg::RX_START: begin
        if (dec) begin
          state_d = vote ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
        end
      end
      uart_rx_pkg::RX_DATA: begin
        if (dec && last_bit) begin
          state_d = uart_rx_pkg::RX_STOP;
        end
      end
      uart_rx_pkg::RX_STOP: begin
        if (dec) begin
          // A low stop level means a break or bad frame; wait for high.
          state_d = vote ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_BREAK;
        end
      end
      uart_rx_pkg::RX_BREAK: begin
        if (line_s_q) begin
          state_d = uart_rx_pkg::RX_IDLE;
        end
      end
      default: begin
        state_d = uart_rx_pkg::RX_IDLE;
      end
    endcase
    if (!ctrl_q.rx_enable_bit) begin
      state_d = uart_rx_pkg::RX_IDLE;
    end
  end

  // Phase restarts at the detected edge and then counts sample ticks.
  assign phase_d = (state_q == uart_rx_pkg::RX_IDLE) ? 4'h0 : (tick ? phase_q + 4'h1 : phase_q);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= uart_rx_pkg::RX_IDLE;
      phase_q <= 4'h0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
    end
  end

  // Shift register: least significant bit arrives first, shift right.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= 9'h000;
      bitn_q <= 4'h0;
    end else if (state_q == uart_rx_pkg::RX_START) begin
      bitn_q <= 4'h0;
    end else if (state_q == uart_rx_pkg::RX_DATA && dec) begin
      shift_q <= {vote, shift_q[8:1]};
      bitn_q <= bitn_q + 4'h1;
    end
  end

  // Noise seen anywhere in the frame, stop bit included.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nacc_q <= 1'b0;
    end else if (state_q == uart_rx_pkg::RX_IDLE) begin
      nacc_q <= 1'b0;
    end else if (dec && noisy) begin
      nacc_q <= 1'b1;
    end
  end

  // A frame also ends on a rejected start bit or when the receiver is disabled.
  wire frame_end = word_done || (state_q != uart_rx_pkg::RX_IDLE && state_d == uart_rx_pkg::RX_IDLE);

  // Idle is low from start detection until the frame ends: stop bit sampled, start bit rejected or receiver disabled.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idle_q <= 1'b1;
    end else if (frame_end) begin
      idle_q <= 1'b1;
    end else if (start_det) begin
      idle_q <= 1'b0;
    end
  end

  // ************************************************************
  // Receive FIFO
  // ************************************************************
  wire full = cnt_q == CW'(DEPTH);
  wire empty = cnt_q == '0;
  // The word moves in only after the stop sample and only if room.
  wire push = word_done && !full;
  // A fifth word may finish; it is dropped and the FIFO kept.
  wire ovr_set = word_done && full;
  wire pop = seq_clr && !empty;
  wire frame_noise = nacc_q | noisy;

  // Storage; a break frame has shifted in zeros only.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= {word[8] & nine, word[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= push ? PW'(wp_q + 1'b1) : wp_q;
      rp_q <= pop ? PW'(rp_q + 1'b1) : rp_q;
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end

  wire uart_rx_pkg::word_type head = mem[rp_q];

  // ************************************************************
  // Status flags
  // ************************************************************
  // Hardware sets win over the software clear sequence.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ovr_q <= 1'b0;
      noise_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
    end else begin
      ovr_q <= ovr_set | (ovr_q & ~seq_clr);
      noise_q <= (push & frame_noise) | (noise_q & ~seq_clr);
      fe_q <= (word_done & ~vote) | (fe_q & ~seq_clr);
      pe_q <= (word_done & par_bad) | (pe_q & ~seq_clr);
    end
  end

  // Status read arms the clear; the data read consumes it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      armed_q <= 1'b0;
    end else if (stat_rd) begin
      armed_q <= 1'b1;
    end else if (data_rd) begin
      armed_q <= 1'b0;
    end
  end

  // Trigger field encodes levels one to four; noise adds no request.
  wire [CW:0] trig_lvl = {{(CW-1){1'b0}}, ctrl_q.trig} + 1'b1;
  wire lvl_hit = {1'b0, cnt_q} >= trig_lvl;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= ctrl_q.rx_int_enable & (lvl_hit | ovr_q);
    end
  end

  assign rx_int_req = int_q;

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= uart_rx_pkg::CTRL_RST;
      baud_q <= uart_rx_pkg::BAUD_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end else if (wr && hit_baud) begin
      baud_q <= pwdata[15:0];
    end
  end

  // The ninth bit reads zero while the FIFO is empty; the data port still shows unwritten storage.
  wire [6:0] stat_v = {head.rx_ninth_bit & !empty, idle_q, pe_q, fe_q, noise_q, ovr_q, !empty};

  // Read mux; the shift register has no address of its own.
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_q} :
                       hit_baud ? {16'h0000, baud_q} :
                       hit_stat ? {25'h0000000, stat_v} :
                       hit_data ? {24'h000000, head.data} :
                       hit_cnt ? {{(32-CW){1'b0}}, cnt_q} :
                       32'h00000000;

  // Read data and error are captured in setup so they stand in access.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      slverr_q <= !mapped;
    end
  end

  // Zero wait states: every access ends in its first access cycle.
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q & access;

endmodule : uart_receiver_fifo

// >>> hw/uart_rx_pkg.sv
// Shared constants and types for the UART receive channel.
// Assumes a 25 MHz clk and a 32-bit APB slave port.
package uart_rx_pkg;

  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_CNT = 8'h10;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h000c;

  // Status bit positions.
  localparam int unsigned ST_AVAIL = 0;
  localparam int unsigned ST_OVR = 1;
  localparam int unsigned ST_NOISE = 2;
  localparam int unsigned ST_FRAME = 3;
  localparam int unsigned ST_PAR = 4;
  localparam int unsigned ST_IDLE_B = 5;
  localparam int unsigned ST_NINTH = 6;

  // ************************************************************
  // Oversampling timing, in ticks of the 16x sample clock, and last data bit indices
  // ************************************************************
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] PH_S0 = 4'h7;
  localparam logic [3:0] PH_S2 = 4'h9;
  localparam logic [3:0] PH_DEC = 4'ha;
  localparam logic [3:0] BITS_8 = 4'h7;
  localparam logic [3:0] BITS_9 = 4'h8;

  // Parity type codes; mark and space are not checked.
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [1:0] trig;
    logic rx_int_enable;
    logic [1:0] parity_type_sel;
    logic parity_enable_bit;
    logic word_len_nine_sel;
    logic rx_enable_bit;
  } ctrl_type;

  typedef struct packed {
    logic rx_ninth_bit;
    logic [7:0] data;
  } word_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b011,
    RX_BREAK = 3'b100
  } rx_state_type;

endpackage : uart_rx_pkg
